// ---- bench/pmc_cpu_model.sv ----
// cpu core stand-in: retires one instruction per slot while clocked
// assumes run and slow come from the bench on aclk
`timescale 1ns/10ps
module pmc_cpu_model (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic run,
	input  wire logic slow,
	input  wire logic cpu_clk_run,
	output logic      instr_retire
);
	logic [1:0] gap_q;

	// nops after the request retire only while the core clock runs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			gap_q        <= 2'h0;
			instr_retire <= 1'b0;
		end
		else
		begin
			gap_q        <= gap_q + 2'h1;
			instr_retire <= run && cpu_clk_run && (!slow || gap_q == 2'h3);
		end
	end
endmodule : pmc_cpu_model

// ---- bench/pmc_power_save_ctrl_props.sv ----
// assertions on the power save controller ports
// assumes the register map of pmc_consts.svh; bound at the foot
`timescale 1ns/10ps
`include "pmc_consts.svh"
module pmc_power_save_ctrl_props (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        instr_retire,
	input wire logic        irq_ack_allow,
	input wire logic        cpu_clk_run,
	input wire logic        main_osc_en,
	input wire logic        pll_run,
	input wire logic        spread_spectrum_generator_run,
	input wire logic [1:0]  cpu_clk_div
);
	logic [7:0] aw_q;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// address of the write whose response is pending
	always_ff @(posedge aclk)
	begin
		if (s_axi_awvalid && s_axi_awready)
			aw_q <= s_axi_awaddr;
	end

	a_bresp_unmapped: assert property ($rose(s_axi_bvalid) |->
		s_axi_bresp == ((aw_q > `PMC_A_IMASK) ? `PMC_RESP_SLVERR : `PMC_RESP_OKAY))
		else $error("write response code wrong");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_unlock_hold: assert property ($rose(s_axi_bvalid) && aw_q == `PMC_A_UNLOCK && !instr_retire
		&& !$past(instr_retire) |-> !irq_ack_allow)
		else $error("acknowledge allowed after unlock");
	a_sleep_stops_pll: assert property (!cpu_clk_run |-> !pll_run && !spread_spectrum_generator_run)
		else $error("pll running while asleep");
	a_osc_off_asleep: assert property (!main_osc_en |-> !cpu_clk_run)
		else $error("oscillator off while awake");
	a_wake_div_clear: assert property ($rose(cpu_clk_run) |-> ##[0:2] cpu_clk_div == 2'h0)
		else $error("cpu divider not cleared on wake");
endmodule : pmc_power_save_ctrl_props

bind pmc_power_save_ctrl pmc_power_save_ctrl_props u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .instr_retire, .irq_ack_allow, .cpu_clk_run, .main_osc_en, .pll_run,
	.spread_spectrum_generator_run, .cpu_clk_div);

// ---- bench/testbench.sv ----
// bench for the power save controller through its register bus
// assumes pmc_cpu_model as the core and the bound checker
`timescale 1ns/10ps
`include "pmc_consts.svh"
module testbench;
	localparam logic [1:0] OK = `PMC_RESP_OKAY;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
	logic        run, slow, retire, ack_ok, clk_run, lp_act, osc_en, pll_on, spread_spectrum_generator_on, bready, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [15:0] irq_req;
	int          err_count, checks_done;

	pmc_power_save_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_req(irq_req),
		.instr_retire(retire), .irq_ack_allow(ack_ok), .cpu_clk_run(clk_run), .lp_active(lp_act),
		.main_osc_en(osc_en), .pll_run(pll_on), .spread_spectrum_generator_run(spread_spectrum_generator_on), .periph_clk_en(), .spread_sel(),
		.aux_sel(), .cpu_clk_src(), .cpu_clk_div(), .wdt_clk_sel(), .wt_clk_sel(), .disp_clk_sel());
	pmc_cpu_model u_cpu (.aclk(aclk), .aresetn(aresetn), .run(run), .slow(slow), .cpu_clk_run(clk_run),
		.instr_retire(retire));

	always #4 aclk = ~aclk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = OK);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		// ready only after valid, so the response has to stand a cycle
		bready <= 1'b1;
		@(posedge aclk);
		bready <= 1'b0;
		chk({bvalid, bresp}, {1'b1, er});
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = OK);
		araddr  <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b1;
		@(posedge aclk);
		rready <= 1'b0;
		chk({rvalid, rresp}, {1'b1, er});
		chk(rdata, e);
	endtask : rc

	// bounded wait on the low-power indication
	task automatic wt(input logic v);
		int n;
		n = 0;
		while (lp_act !== v && n < 200)
		begin
			@(posedge aclk);
			n++;
		end
	endtask : wt

	task automatic final_report;
		if (err_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	initial
	begin
		repeat (20000)
			@(posedge aclk);
		err_count++;
		final_report();
	end

	initial
	begin
		aclk        = 1'b0;
		aresetn     = 1'b0;
		awvalid     = 1'b0;
		wvalid      = 1'b0;
		arvalid     = 1'b0;
		bready      = 1'b0;
		rready      = 1'b0;
		awaddr      = 8'h00;
		araddr      = 8'h00;
		wdata       = 32'h0;
		irq_req     = 16'h0;
		run         = 1'b0;
		slow        = 1'b0;
		err_count   = 0;
		checks_done = 0;
		repeat (2)
			@(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(8'h28, 32'hffff);
		rc(8'h08, 32'h0);
		wr(8'h2c, 32'h1, `PMC_RESP_SLVERR);
		rc(8'h2c, 32'h0, `PMC_RESP_SLVERR);
		wr(8'h18, 32'h3);
		wr(8'h18, 32'h1);
		rc(8'h18, 32'h3);
		wr(8'h24, 32'h15);
		wr(8'h24, 32'h2a);
		rc(8'h24, 32'h15);
		wr(8'h08, 32'h3);
		rc(8'h08, 32'h0);
		wr(8'h04, 32'h7);
		chk(ack_ok, 1'b0);
		wr(8'h08, 32'h3);
		chk(ack_ok, 1'b1);
		rc(8'h08, 32'h0);
		wr(8'h04, 32'h3);
		wr(8'h00, 32'h6);
		wr(8'h08, 32'h3);
		rc(8'h08, 32'h0);
		wr(8'h0c, 32'h7);
		wr(8'h10, 32'h3);
		wr(8'h14, 32'h3);
		wr(8'h28, 32'hfffe);
		slow <= 1'b1;
		run  <= 1'b1;
		wr(8'h04, 32'h3);
		wr(8'h08, 32'h3);
		wt(1'b1);
		chk({lp_act, osc_en, pll_on, spread_spectrum_generator_on}, 4'h8);
		irq_req <= 16'h0002;
		repeat (8)
			@(posedge aclk);
		chk(lp_act, 1'b1);
		irq_req <= 16'h0003;
		wt(1'b0);
		irq_req <= 16'h0;
		run     <= 1'b0;
		rc(8'h20, 32'h3);
		rc(8'h0c, 32'h0);
		rc(8'h14, 32'h0);
		rc(8'h18, 32'h4);
		rc(8'h08, 32'h2);
		wr(8'h18, 32'h1);
		rc(8'h18, 32'h1);
		irq_req <= 16'h0001;
		wr(8'h04, 32'h3);
		wr(8'h08, 32'h3);
		irq_req <= 16'h0;
		rc(8'h20, 32'h3);
		rc(8'h18, 32'h1);
		wr(8'h0c, 32'h3);
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h3);
		wr(8'h08, 32'h3);
		rc(8'h20, 32'he);
		irq_req <= 16'h0001;
		repeat (4)
			@(posedge aclk);
		irq_req <= 16'h0;
		rc(8'h20, 32'he);
		rc(8'h18, 32'h0);
		wr(8'h0c, 32'h7);
		wr(8'h1c, 32'h1);
		rc(8'h0c, 32'h3);
		rc(8'h20, 32'he);
		wr(8'h18, 32'h3);
		wr(8'h00, 32'h1);
		run <= 1'b1;
		wr(8'h04, 32'h3);
		wr(8'h08, 32'h3);
		wt(1'b1);
		chk({lp_act, osc_en, pll_on, spread_spectrum_generator_on}, 4'h8);
		irq_req <= 16'h0001;
		wt(1'b0);
		irq_req <= 16'h0;
		rc(8'h20, 32'h3);
		rc(8'h0c, 32'h0);
		rc(8'h18, 32'h0);
		wr(8'h18, 32'h3);
		wr(8'h00, 32'h3);
		wr(8'h04, 32'h3);
		wr(8'h08, 32'h3);
		// no bus access while the core sleeps
		wt(1'b1);
		chk({lp_act, osc_en}, 2'h2);
		irq_req <= 16'h0001;
		wt(1'b0);
		irq_req <= 16'h0;
		rc(8'h18, 32'h0);
		rc(8'h20, 32'h3);
		final_report();
	end
endmodule : testbench

// ---- hw/pmc_axil_slave.sv ----
// AXI4-Lite slave front end: one write and one read at a time
// assumes the parent decodes addresses combinationally and returns hit flags
`timescale 1ns/10ps
`include "pmc_consts.svh"
module pmc_axil_slave (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [`PMC_AW-1:0]    awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [`PMC_AW-1:0]    araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	output logic                       wr_en,
	output logic [`PMC_AW-1:0]         wr_addr,
	output logic [31:0]                wr_data,
	output logic [3:0]                 wr_strb,
	input  wire logic                  wr_ok,
	output logic [`PMC_AW-1:0]         rd_addr,
	input  wire logic [31:0]           rd_data,
	input  wire logic                  rd_ok
);
	logic aw_full_q;
	logic w_full_q;

	assign awready = ~aw_full_q & ~bvalid;
	assign wready  = ~w_full_q & ~bvalid;
	assign wr_en   = aw_full_q & w_full_q & ~bvalid;
	assign arready = ~rvalid;
	assign rd_addr = araddr;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			wr_addr   <= '0;
			wr_data   <= 32'h0;
			wr_strb   <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= `PMC_RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_full_q <= 1'b1;
				wr_addr   <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_full_q <= 1'b1;
				wr_data  <= wdata;
				wr_strb  <= wstrb;
			end
			if (wr_en)
			begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				bvalid    <= 1'b1;
				bresp     <= wr_ok ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0;
			rresp  <= `PMC_RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rdata  <= rd_ok ? rd_data : 32'h0;
			rresp  <= rd_ok ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
	end
endmodule : pmc_axil_slave

// ---- hw/pmc_consts.svh ----
// register offsets, field positions, reset values and counts of the power save controller
// assumes a 32-bit AXI4-Lite register bus with byte addresses
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

`define PMC_AW             8
`define PMC_A_MODE         8'h00
`define PMC_A_UNLOCK       8'h04
`define PMC_A_STBY         8'h08
`define PMC_A_CLKCTL       8'h0c
`define PMC_A_SCC          8'h10
`define PMC_A_ICC          8'h14
`define PMC_A_CPUCLK       8'h18
`define PMC_A_DFLT         8'h1c
`define PMC_A_STAT         8'h20
`define PMC_A_PSEL         8'h24
`define PMC_A_IMASK        8'h28

`define PMC_MODE_IDLE      2'h0
`define PMC_MODE_STOP      2'h1
`define PMC_MODE_TKEEP     2'h2
`define PMC_MODE_SUBTK     2'h3
`define PMC_B_MAIN_OSC_DISABLE_BIT       2
`define PMC_B_STP          0
`define PMC_B_WAKE_IRQ     1
`define PMC_B_PLLEN        0
`define PMC_B_SCEN         1
`define PMC_B_PERIPHERAL_CLOCK_ENABLE_BIT        2
`define PMC_B_CPUSRC       2
`define PMC_B_DFLTRQ       0

`define PMC_RST_IMASK      16'hffff
`define PMC_RST_STBY       8'h00
`define PMC_ENTRY_SLOTS    3'h5
`define PMC_RESP_OKAY      2'h0
`define PMC_RESP_SLVERR    2'h2

`endif

// ---- hw/pmc_entry_seq.sv ----
// power save entry sequencer: counts instruction slots after a request
// assumes req, wake and slot come from logic on aclk
`timescale 1ns/10ps
`include "pmc_consts.svh"
module pmc_entry_seq (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic req,
	input  wire logic wake,
	input  wire logic slot,
	output logic      accept,
	output logic      reject,
	output logic      cfg,
	output logic      complete,
	output logic      asleep
);
	pmc_pkg::pmc_state_t state_q;
	logic [2:0]          cnt_q;

	assign asleep = (state_q == pmc_pkg::ST_SLEEP);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q  <= pmc_pkg::ST_IDLE;
			cnt_q    <= 3'h0;
			accept   <= 1'b0;
			reject   <= 1'b0;
			cfg      <= 1'b0;
			complete <= 1'b0;
		end
		else
		begin
			accept   <= 1'b0;
			reject   <= 1'b0;
			cfg      <= 1'b0;
			complete <= 1'b0;
			case (state_q)
				pmc_pkg::ST_IDLE:
					if (req && wake)
						reject <= 1'b1;
					else if (req)
					begin
						accept  <= 1'b1;
						cnt_q   <= 3'h0;
						state_q <= pmc_pkg::ST_ENTRY;
					end
				pmc_pkg::ST_ENTRY:
					if (wake)
					begin
						cfg     <= 1'b1;
						state_q <= pmc_pkg::ST_IDLE;
					end
					else if (slot)
					begin
						cnt_q <= cnt_q + 3'h1;
						if (cnt_q == `PMC_ENTRY_SLOTS - 3'h1)
							state_q <= pmc_pkg::ST_SLEEP;
					end
				pmc_pkg::ST_SLEEP:
					if (wake)
					begin
						cfg      <= 1'b1;
						complete <= 1'b1;
						state_q  <= pmc_pkg::ST_IDLE;
					end
				default:
					state_q <= pmc_pkg::ST_IDLE;
			endcase
		end
	end
endmodule : pmc_entry_seq

// ---- hw/pmc_pkg.sv ----
// types of the power save controller
// constants live in pmc_consts.svh
package pmc_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_SLEEP} pmc_state_t;
	typedef logic [1:0] pmc_mode_t;
endpackage : pmc_pkg

// ---- hw/pmc_power_save_ctrl.sv ----
// power save entry and wake-up controller with AXI4-Lite registers
// assumes irq_req and instr_retire come from the cpu on aclk
`timescale 1ns/10ps
`include "pmc_consts.svh"
module pmc_power_save_ctrl (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [`PMC_AW-1:0]    s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [`PMC_AW-1:0]    s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic [15:0]           irq_req,
	input  wire logic                  instr_retire,
	output logic                       irq_ack_allow,
	output logic                       cpu_clk_run,
	output logic                       lp_active,
	output logic                       main_osc_en,
	output logic                       pll_run,
	output logic                       spread_spectrum_generator_run,
	output logic                       periph_clk_en,
	output logic [1:0]                 spread_sel,
	output logic [1:0]                 aux_sel,
	output logic                       cpu_clk_src,
	output logic [1:0]                 cpu_clk_div,
	output logic [1:0]                 wdt_clk_sel,
	output logic [1:0]                 wt_clk_sel,
	output logic [1:0]                 disp_clk_sel
);
	logic                 wr_en;
	logic [`PMC_AW-1:0]   wr_addr;
	logic [31:0]          wr_data;
	logic [3:0]           wr_strb;
	logic                 wr_ok;
	logic [`PMC_AW-1:0]   rd_addr;
	logic [31:0]          rd_data;
	logic                 rd_ok;
	pmc_pkg::pmc_mode_t   mode_q;
	pmc_pkg::pmc_mode_t   ent_mode_q;
	logic                 osc_dis_q;
	logic                 ent_osc_q;
	logic                 unlock_q;
	logic [7:0]           unlock_data_q;
	logic [7:0]           stby_q;
	logic                 pll_en_q;
	logic                 scen_q;
	logic                 peripheral_clock_enable_bit_q;
	logic [1:0]           scc_sel_q;
	logic [1:0]           icc_sel_q;
	logic                 cpu_src_q;
	logic [1:0]           cpu_div_q;
	logic                 cpu_lock_q;
	logic [1:0]           wdt_sel_q;
	logic [1:0]           wt_sel_q;
	logic [1:0]           disp_sel_q;
	logic [2:0]           psel_lock_q;
	logic [15:0]          imask_q;
	logic                 flag_q;
	logic                 irq_hold_q;
	logic                 hold_cnt_q;
	logic                 w_mode;
	logic                 w_unlock;
	logic                 w_stby;
	logic                 w_clk;
	logic                 w_scc;
	logic                 w_icc;
	logic                 w_cpu;
	logic                 w_dflt;
	logic                 w_psel;
	logic                 w_imask;
	logic                 prot_ok;
	logic                 req;
	logic                 wake;
	logic                 accept;
	logic                 reject;
	logic                 cfg;
	logic                 complete;
	logic                 asleep;
	logic                 dflt;
	logic                 clr_clk;
	logic                 clr_cpu;
	logic                 load_cpu;
	logic                 osc_stop;

	function automatic logic reg_hit(input logic [`PMC_AW-1:0] a);
		reg_hit = (a == `PMC_A_MODE) || (a == `PMC_A_UNLOCK) || (a == `PMC_A_STBY)
			|| (a == `PMC_A_CLKCTL) || (a == `PMC_A_SCC) || (a == `PMC_A_ICC)
			|| (a == `PMC_A_CPUCLK) || (a == `PMC_A_DFLT) || (a == `PMC_A_STAT)
			|| (a == `PMC_A_PSEL) || (a == `PMC_A_IMASK);
	endfunction : reg_hit

	function automatic logic wr_to(input logic en, input logic [`PMC_AW-1:0] a,
		input logic [`PMC_AW-1:0] target, input logic lane0);
		wr_to = en && (a == target) && lane0;
	endfunction : wr_to

	pmc_axil_slave u_bus (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_ok   (wr_ok),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_ok   (rd_ok)
	);

	pmc_entry_seq u_seq (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.req      (req),
		.wake     (wake),
		.slot     (instr_retire),
		.accept   (accept),
		.reject   (reject),
		.cfg      (cfg),
		.complete (complete),
		.asleep   (asleep)
	);

	assign wr_ok    = reg_hit(wr_addr);
	assign rd_ok    = reg_hit(rd_addr);
	assign w_mode   = wr_to(wr_en, wr_addr, `PMC_A_MODE, wr_strb[0]);
	assign w_unlock = wr_to(wr_en, wr_addr, `PMC_A_UNLOCK, wr_strb[0]);
	assign w_stby   = wr_to(wr_en, wr_addr, `PMC_A_STBY, wr_strb[0]);
	assign w_clk    = wr_to(wr_en, wr_addr, `PMC_A_CLKCTL, wr_strb[0]);
	assign w_scc    = wr_to(wr_en, wr_addr, `PMC_A_SCC, wr_strb[0]);
	assign w_icc    = wr_to(wr_en, wr_addr, `PMC_A_ICC, wr_strb[0]);
	assign w_cpu    = wr_to(wr_en, wr_addr, `PMC_A_CPUCLK, wr_strb[0]);
	assign w_dflt   = wr_to(wr_en, wr_addr, `PMC_A_DFLT, wr_strb[0]);
	assign w_psel   = wr_to(wr_en, wr_addr, `PMC_A_PSEL, wr_strb[0]);
	assign w_imask  = wr_en && (wr_addr == `PMC_A_IMASK);

	// protected write: previous write unlocked and data match
	assign prot_ok = w_stby && unlock_q && (wr_data[7:0] == unlock_data_q);
	assign req     = prot_ok && wr_data[`PMC_B_STP];
	// mask and the stby_q wake enable bit decide wake, acknowledge blocking plays no part
	assign wake    = stby_q[`PMC_B_WAKE_IRQ] && |(irq_req & ~imask_q);
	assign dflt    = w_dflt && wr_data[`PMC_B_DFLTRQ];

	assign clr_clk  = cfg && (ent_mode_q != `PMC_MODE_IDLE);
	assign clr_cpu  = cfg && ((ent_mode_q == `PMC_MODE_IDLE) || (ent_mode_q == `PMC_MODE_STOP));
	assign load_cpu = cfg && ent_mode_q[1];
	assign osc_stop = (ent_mode_q == `PMC_MODE_STOP) || (ent_mode_q == `PMC_MODE_SUBTK)
		|| ((ent_mode_q == `PMC_MODE_TKEEP) && ent_osc_q);

	assign main_osc_en   = ~(asleep && osc_stop);
	assign pll_run       = pll_en_q && ~asleep;
	assign spread_spectrum_generator_run      = scen_q && ~asleep;
	assign cpu_clk_run   = ~asleep;
	assign lp_active     = asleep;
	assign irq_ack_allow = ~irq_hold_q;
	assign periph_clk_en = peripheral_clock_enable_bit_q;
	assign spread_sel    = scc_sel_q;
	assign aux_sel       = icc_sel_q;
	assign cpu_clk_src   = cpu_src_q;
	assign cpu_clk_div   = cpu_div_q;
	assign wdt_clk_sel   = wdt_sel_q;
	assign wt_clk_sel    = wt_sel_q;
	assign disp_clk_sel  = disp_sel_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_q     <= `PMC_MODE_IDLE;
			osc_dis_q  <= 1'b0;
			ent_mode_q <= `PMC_MODE_IDLE;
			ent_osc_q  <= 1'b0;
		end
		else
		begin
			if (w_mode)
			begin
				mode_q    <= wr_data[1:0];
				osc_dis_q <= wr_data[`PMC_B_MAIN_OSC_DISABLE_BIT];
			end
			if (req)
			begin
				ent_mode_q <= mode_q;
				ent_osc_q  <= osc_dis_q;
			end
		end
	end

	// any write after the unlock write consumes the unlock
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			unlock_q      <= 1'b0;
			unlock_data_q <= 8'h00;
		end
		else if (w_unlock)
		begin
			unlock_q      <= 1'b1;
			unlock_data_q <= wr_data[7:0];
		end
		else if (wr_en)
			unlock_q <= 1'b0;
	end

	// acknowledge held until the instruction after the unlock store ends or the next bus write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_hold_q <= 1'b0;
			hold_cnt_q <= 1'b0;
		end
		else if (w_unlock)
		begin
			irq_hold_q <= 1'b1;
			hold_cnt_q <= 1'b0;
		end
		else if (irq_hold_q && (wr_en || (instr_retire && hold_cnt_q)))
			irq_hold_q <= 1'b0;
		else if (irq_hold_q && instr_retire)
			hold_cnt_q <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			stby_q <= `PMC_RST_STBY;
		else if (prot_ok)
			stby_q <= wr_data[7:0];
		else if (cfg || reject)
			stby_q[`PMC_B_STP] <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pll_en_q  <= 1'b0;
			scen_q    <= 1'b0;
			peripheral_clock_enable_bit_q   <= 1'b0;
			scc_sel_q <= 2'h0;
			icc_sel_q <= 2'h0;
		end
		else if (clr_clk)
		begin
			pll_en_q  <= 1'b0;
			scen_q    <= 1'b0;
			peripheral_clock_enable_bit_q   <= 1'b0;
			scc_sel_q <= 2'h0;
			icc_sel_q <= 2'h0;
		end
		else if (dflt)
		begin
			peripheral_clock_enable_bit_q   <= 1'b0;
			scc_sel_q <= 2'h0;
			icc_sel_q <= 2'h0;
		end
		else
		begin
			if (w_clk)
			begin
				pll_en_q <= wr_data[`PMC_B_PLLEN];
				scen_q   <= wr_data[`PMC_B_SCEN];
				peripheral_clock_enable_bit_q  <= wr_data[`PMC_B_PERIPHERAL_CLOCK_ENABLE_BIT];
			end
			if (w_scc)
				scc_sel_q <= wr_data[1:0];
			if (w_icc)
				icc_sel_q <= wr_data[1:0];
		end
	end

	// one cpu clock switch, rearmed by wake-up or default request
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cpu_src_q  <= 1'b0;
			cpu_div_q  <= 2'h0;
			cpu_lock_q <= 1'b0;
		end
		else if (load_cpu || dflt)
		begin
			cpu_src_q  <= dflt ? osc_dis_q : ent_osc_q;
			cpu_div_q  <= 2'h0;
			cpu_lock_q <= 1'b0;
		end
		else if (clr_cpu)
		begin
			cpu_src_q  <= 1'b0;
			cpu_div_q  <= 2'h0;
			cpu_lock_q <= 1'b0;
		end
		else if (w_cpu && !cpu_lock_q)
		begin
			cpu_src_q  <= wr_data[`PMC_B_CPUSRC];
			cpu_div_q  <= wr_data[1:0];
			cpu_lock_q <= 1'b1;
		end
	end

	// each peripheral select field takes one write per reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wdt_sel_q   <= 2'h0;
			wt_sel_q    <= 2'h0;
			disp_sel_q  <= 2'h0;
			psel_lock_q <= 3'h0;
		end
		else if (w_psel)
		begin
			if (!psel_lock_q[0])
				wdt_sel_q <= wr_data[1:0];
			if (!psel_lock_q[1])
				wt_sel_q <= wr_data[3:2];
			if (!psel_lock_q[2])
				disp_sel_q <= wr_data[5:4];
			psel_lock_q <= 3'h7;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			imask_q <= `PMC_RST_IMASK;
		else if (w_imask)
		begin
			if (wr_strb[0])
				imask_q[7:0] <= wr_data[7:0];
			if (wr_strb[1])
				imask_q[15:8] <= wr_data[15:8];
		end
	end

	// accept and complete never coincide, so no set/clear clash
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flag_q <= 1'b0;
		else if (complete)
			flag_q <= 1'b1;
		else if (accept)
			flag_q <= 1'b0;
	end

	always_comb
	begin
		rd_data = 32'h0;
		if (rd_addr == `PMC_A_MODE)
			rd_data = {29'h0, osc_dis_q, mode_q};
		else if (rd_addr == `PMC_A_STBY)
			rd_data = {24'h0, stby_q};
		else if (rd_addr == `PMC_A_CLKCTL)
			rd_data = {29'h0, peripheral_clock_enable_bit_q, scen_q, pll_en_q};
		else if (rd_addr == `PMC_A_SCC)
			rd_data = {30'h0, scc_sel_q};
		else if (rd_addr == `PMC_A_ICC)
			rd_data = {30'h0, icc_sel_q};
		else if (rd_addr == `PMC_A_CPUCLK)
			rd_data = {29'h0, cpu_src_q, cpu_div_q};
		else if (rd_addr == `PMC_A_STAT)
			rd_data = {26'h0, irq_hold_q, asleep, spread_spectrum_generator_run, pll_run, main_osc_en, flag_q};
		else if (rd_addr == `PMC_A_PSEL)
			rd_data = {26'h0, disp_sel_q, wt_sel_q, wdt_sel_q};
		else if (rd_addr == `PMC_A_IMASK)
			rd_data = {16'h0, imask_q};
	end
endmodule : pmc_power_save_ctrl
